// ===== logic/adcop_pkg.sv
// Shared constants for the converter output-path control block.
// Assumes one sample clock; no software-reachable registers.
package adcop_pkg;
   localparam int unsigned DATA_W         = 12;
   localparam int unsigned FAST_LATENCY   = 10;
   localparam int unsigned PROC_EXTRA     = 3;
   localparam int unsigned SLOW_LATENCY   = FAST_LATENCY + PROC_EXTRA;
   localparam int unsigned GAIN_W         = 4;
   localparam int unsigned GAIN_STEPS     = 13;
   localparam logic [3:0]  GAIN_MAX_CODE  = 4'hC;
   localparam logic [3:0]  GAIN_RESET     = 4'h0;
   localparam int unsigned FIFO_DEPTH     = 8;
   localparam int unsigned FRAC_W         = 14;
   localparam logic [11:0] MID_CODE       = 12'h800;
   localparam logic [11:0] MAX_CODE       = 12'hFFF;
   // Gain factors, 2.14 fixed point: 10^(k*0.5/20) for k=0..12
   localparam logic [15:0] GAIN_TAB [GAIN_STEPS] = '{
      16'h4000, 16'h43CE, 16'h47D6, 16'h4C19, 16'h509C, 16'h5564, 16'h5A67,
      16'h5FB2, 16'h6549, 16'h6B33, 16'h7175, 16'h7817, 16'h7F1E};
   typedef enum logic [2:0] {
      ADCOP_FAST  = 3'h1,
      ADCOP_DRAIN = 3'h2,
      ADCOP_PROC  = 3'h4
   } adcop_mode_e;
endpackage

// ===== logic/adcop_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module adcop_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ===== logic/adcop_path.sv
// Output-path control: fast bypass, gain stage, output FIFO.
// Assumes raw samples arrive one per clock, synchronous to clock.
//
// Functional notes
// (RULE1) After reset, raw samples reach outputs exactly 10 clocks after capture.
// (RULE2) Fast path bypasses gain and every other digital function; the code still applies the twos_comp_sel output format to it.
// (RULE3) Processed path adds extra pipeline cycles beyond the fast latency.
// (RULE4) Any reset selects the fast path.
// (RULE5) Host sets disable bit before programming gain settings.
// (RULE6) Gain 0 to 6 dB in half-dB steps.
// (RULE7) Setting the disable bit enables gain, starting at 0 dB.
// (RULE8) Gain inactive immediately after reset.
// (RULE9) Full scale shrinks proportionally with gain, 2 Vpp to 1 Vpp.
// (RULE10) A sample is captured on each rising clock edge.
// (RULE11) Output words are 12 bits, offset binary or two's complement.
// (RULE12) Gain code 0..12, one per half dB, code 0 is 0 dB.
// (RULE13) Mode or gain changes act on clock edges; transition words invalid.
`timescale 1ns/1ps
`default_nettype none
module adcop_path (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [11:0] raw_sample,
   input  wire logic        fast_path_disable_bit,
   input  wire logic [3:0]  gain_code,
   input  wire logic        twos_comp_sel,
   output logic      [11:0] out_data,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic             overflow,
   output logic             gain_active
);
   localparam int unsigned LAT = adcop_pkg::SLOW_LATENCY;

   // ------------------------------------------------------------
   // Capture and delay line
   // ------------------------------------------------------------
   logic [11:0] dly_q [LAT];
   logic [LAT-1:0] vld_q;
   adcop_pkg::adcop_mode_e mode_q;
   logic [3:0]  gain_q;
   logic        flush;

   always_ff @(posedge clock) begin
      dly_q[0] <= raw_sample; // RULE10
   end
   genvar gi;
   generate
      for (gi = 1; gi < LAT; gi++) begin : g_dly
         always_ff @(posedge clock) begin
            dly_q[gi] <= dly_q[gi-1];
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Mode control
   // ------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_q <= adcop_pkg::ADCOP_FAST; // RULE4 RULE8
      end else begin
         case (mode_q)
            adcop_pkg::ADCOP_FAST: begin
               if (fast_path_disable_bit) begin
                  mode_q <= adcop_pkg::ADCOP_DRAIN;
               end
            end
            adcop_pkg::ADCOP_DRAIN: begin
               mode_q <= fast_path_disable_bit ? adcop_pkg::ADCOP_PROC
                                               : adcop_pkg::ADCOP_FAST;
            end
            adcop_pkg::ADCOP_PROC: begin
               if (!fast_path_disable_bit) begin
                  mode_q <= adcop_pkg::ADCOP_DRAIN;
               end
            end
            default: mode_q <= adcop_pkg::ADCOP_FAST;
         endcase
      end
   end

   // Gain held at 0 dB outside processed mode and on leaving it; codes above 12 clamp.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gain_q <= adcop_pkg::GAIN_RESET; // RULE7
      end else if (mode_q != adcop_pkg::ADCOP_PROC || !fast_path_disable_bit) begin
         gain_q <= adcop_pkg::GAIN_RESET; // RULE7 RULE8
      end else if (gain_code > adcop_pkg::GAIN_MAX_CODE) begin
         gain_q <= adcop_pkg::GAIN_MAX_CODE; // RULE12
      end else begin
         gain_q <= gain_code; // RULE6 RULE12
      end
   end

   logic [3:0] gain_prev_q;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gain_prev_q <= adcop_pkg::GAIN_RESET;
      end else begin
         gain_prev_q <= gain_q;
      end
   end

   // Any mode or gain change invalidates words in flight
   assign flush = (mode_q == adcop_pkg::ADCOP_DRAIN) || (gain_q != gain_prev_q); // RULE13

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         vld_q <= '0;
      end else if (flush) begin
         vld_q <= '0; // RULE13
      end else begin
         vld_q <= {vld_q[LAT-2:0], 1'b1};
      end
   end

   assign gain_active = (mode_q == adcop_pkg::ADCOP_PROC);

   // ------------------------------------------------------------
   // Gain stage: signed around mid code, saturating
   // ------------------------------------------------------------
   logic signed [12:0] ctr;
   logic signed [29:0] prod;
   logic signed [15:0] scaled;
   logic [11:0]        gained;
   logic               sat;
   always_comb begin
      ctr    = $signed({1'b0, dly_q[adcop_pkg::FAST_LATENCY-1]}) -
               $signed({1'b0, adcop_pkg::MID_CODE});
      prod   = 30'(ctr * $signed({1'b0, adcop_pkg::GAIN_TAB[gain_q]})); // RULE9
      scaled = 16'(prod >>> adcop_pkg::FRAC_W);
      sat    = 1'b0;
      if (scaled > 16'sh07FF) begin
         gained = adcop_pkg::MAX_CODE;
         sat    = 1'b1;
      end else if (scaled < -16'sh0800) begin
         gained = 12'h000;
         sat    = 1'b1;
      end else begin
         gained = 12'(scaled) ^ adcop_pkg::MID_CODE;
      end
   end

   // Extra stages of the processed path
   logic [11:0] proc_q [adcop_pkg::PROC_EXTRA];
   logic        sat_q;
   always_ff @(posedge clock) begin
      proc_q[0] <= gained;
   end
   generate
      for (gi = 1; gi < adcop_pkg::PROC_EXTRA; gi++) begin : g_proc
         always_ff @(posedge clock) begin
            proc_q[gi] <= proc_q[gi-1]; // RULE3
         end
      end
   endgenerate
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sat_q <= 1'b0;
      end else begin
         sat_q <= gain_active && sat;
      end
   end
   assign overflow = sat_q;

   // ------------------------------------------------------------
   // Output select, format and FIFO
   // ------------------------------------------------------------
   logic [11:0] sel_word;
   logic        sel_vld;
   always_comb begin
      if (gain_active) begin
         sel_word = proc_q[adcop_pkg::PROC_EXTRA-1]; // RULE3
         sel_vld  = vld_q[LAT-1];
      end else begin
         sel_word = dly_q[adcop_pkg::FAST_LATENCY-2]; // RULE1 RULE2
         sel_vld  = vld_q[adcop_pkg::FAST_LATENCY-2];
      end
   end

   logic [11:0] fmt_q;
   logic        fmt_vld_q;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fmt_q     <= '0;
         fmt_vld_q <= 1'b0;
      end else begin
         fmt_q     <= twos_comp_sel ? {~sel_word[11], sel_word[10:0]} : sel_word; // RULE11
         fmt_vld_q <= sel_vld && !flush;
      end
   end

   // Fast path total: capture, 8 stages, format, FIFO write = 11 edges.
   adcop_fifo #(
      .WIDTH (adcop_pkg::DATA_W),
      .DEPTH (adcop_pkg::FIFO_DEPTH)
   ) i_adcop_fifo (
      .clock     (clock),
      .rst       (rst),
      .flush     (flush),
      .in_valid  (fmt_vld_q),
      .in_ready  (),
      .in_data   (fmt_q),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_reset_fast;
      @(posedge clock) $fell(rst) |-> mode_q == adcop_pkg::ADCOP_FAST;
   endproperty
   a_reset_fast: assert property (p_reset_fast) else $error("not fast after reset"); // RULE4

   property p_gain_off;
      @(posedge clock) disable iff (rst) !fast_path_disable_bit |=> !gain_active;
   endproperty
   a_gain_off: assert property (p_gain_off) else $error("gain active in fast mode"); // RULE8

   property p_gain_zero;
      @(posedge clock) disable iff (rst) !gain_active |-> gain_q == adcop_pkg::GAIN_RESET;
   endproperty
   a_gain_zero: assert property (p_gain_zero) else $error("gain not 0 dB"); // RULE7

   property p_gain_range;
      @(posedge clock) disable iff (rst) gain_q <= adcop_pkg::GAIN_MAX_CODE;
   endproperty
   a_gain_range: assert property (p_gain_range) else $error("gain code out of range"); // RULE6

   property p_fast_lat;
      @(posedge clock) disable iff (rst)
         (!gain_active && !flush && vld_q[adcop_pkg::FAST_LATENCY-2] && !twos_comp_sel)
         |=> fmt_q == $past(raw_sample, adcop_pkg::FAST_LATENCY);
   endproperty
   a_fast_lat: assert property (p_fast_lat) else $error("fast latency wrong"); // RULE1 RULE2

   property p_flush_inval;
      @(posedge clock) disable iff (rst) flush |=> !fmt_vld_q;
   endproperty
   a_flush_inval: assert property (p_flush_inval) else $error("word valid in transition"); // RULE13

   property p_proc_zero_db;
      @(posedge clock) disable iff (rst)
         (gain_active && gain_q == adcop_pkg::GAIN_RESET)
         |-> gained == dly_q[adcop_pkg::FAST_LATENCY-1];
   endproperty
   a_proc_zero_db: assert property (p_proc_zero_db) else $error("0 dB not unity"); // RULE9

   property p_enter_proc;
      @(posedge clock) disable iff (rst)
         (mode_q == adcop_pkg::ADCOP_FAST && fast_path_disable_bit) ##1 fast_path_disable_bit
         |=> gain_active;
   endproperty
   a_enter_proc: assert property (p_enter_proc) else $error("gain not enabled"); // RULE7

   c_fast_out: cover property (@(posedge clock) disable iff (rst) !gain_active && out_valid);
   c_proc_out: cover property (@(posedge clock) disable iff (rst) gain_active && out_valid);
   c_max_gain: cover property (@(posedge clock) disable iff (rst)
                               gain_q == adcop_pkg::GAIN_MAX_CODE);
   c_sat:      cover property (@(posedge clock) disable iff (rst) overflow);
endmodule
`default_nettype wire

// ===== tb/tb_adcop_path.sv
// Self-checking bench for the output-path control block.
// Assumes the design files under logic/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_adcop_path;
   logic        clock;
   logic        rst;
   logic [11:0] raw_sample;
   logic        fast_path_disable_bit;
   logic [3:0]  gain_code;
   logic        twos_comp_sel;
   logic [11:0] out_data;
   logic        out_valid;
   logic        out_ready;
   logic        overflow;
   logic        gain_active;
   logic        ramp;
   logic [11:0] fixed_val;
   int          num_errors;
   int          n_tests;
   int          cyc;

   adcop_path i_adcop_path (
      .clock                 (clock),
      .rst                   (rst),
      .raw_sample            (raw_sample),
      .fast_path_disable_bit (fast_path_disable_bit),
      .gain_code             (gain_code),
      .twos_comp_sel         (twos_comp_sel),
      .out_data              (out_data),
      .out_valid             (out_valid),
      .out_ready             (out_ready),
      .overflow              (overflow),
      .gain_active           (gain_active)
   );

   // ----------------------------------------
   // Clock, stimulus source, timeout
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Ramp makes the latency visible as a constant difference
   always @(negedge clock) raw_sample <= ramp ? raw_sample + 12'h001 : fixed_val;

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cmp12(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Gain rounding is the designer's: one code either way
   task automatic cmp_near(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp && got !== exp + 12'h001 && got !== exp - 12'h001) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic waitn(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic lat_check(input logic [11:0] lat);
      repeat (4) begin
         @(negedge clock);
         cmp1(out_valid, 1'b1);
         cmp12(raw_sample - out_data, lat);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_fast;
      ramp = 1'b1;
      gain_code = 4'hC;
      waitn(20);
      lat_check(12'h00A);
      cmp1(gain_active, 1'b0);
      $display("done fast path");
   endtask

   task automatic t_proc;
      gain_code = 4'h0;
      fast_path_disable_bit = 1'b1;
      waitn(3);
      cmp1(gain_active, 1'b1);
      waitn(20);
      lat_check(12'h00E);
      $display("done processed path");
   endtask

   task automatic t_gain;
      logic [31:0] e;
      ramp = 1'b0;
      fixed_val = 12'h900;
      for (int k = 0; k < 13; k++) begin
         gain_code = k[3:0];
         waitn(20);
         e = 32'h800 + ((32'h100 * adcop_pkg::GAIN_TAB[k]) >> 14);
         cmp_near(out_data, e[11:0]);
      end
      gain_code = 4'hF;
      waitn(20);
      cmp_near(out_data, e[11:0]);
      fixed_val = 12'hFFF;
      waitn(20);
      cmp12(out_data, adcop_pkg::MAX_CODE);
      cmp1(overflow, 1'b1);
      fixed_val = 12'h000;
      waitn(20);
      cmp12(out_data, 12'h000);
      $display("done gain steps");
   endtask

   task automatic t_twos;
      gain_code = 4'h0;
      fixed_val = 12'h900;
      twos_comp_sel = 1'b1;
      waitn(20);
      cmp12(out_data, 12'h100);
      twos_comp_sel = 1'b0;
      $display("done output format");
   endtask

   task automatic t_fifo;
      logic [11:0] w0;
      logic [11:0] w;
      ramp = 1'b1;
      waitn(20);
      out_ready = 1'b0;
      waitn(30);
      cmp1(out_valid, 1'b1);
      w0 = out_data;
      out_ready = 1'b1;
      for (int i = 1; i < 9; i++) begin
         @(negedge clock);
         w = out_data;
         if (i < 8) begin
            cmp12(w, w0 + i[11:0]);
         end else begin
            cmp1(w !== w0 + 12'h008, 1'b1);
         end
      end
      fast_path_disable_bit = 1'b0;
      waitn(3);
      cmp1(gain_active, 1'b0);
      waitn(20);
      lat_check(12'h00A);
      $display("done buffer stall");
   endtask

   task automatic t_reset2;
      fast_path_disable_bit = 1'b1;
      waitn(20);
      rst = 1'b1;
      fast_path_disable_bit = 1'b0;
      waitn(1);
      cmp1(gain_active, 1'b0);
      cmp1(out_valid, 1'b0);
      rst = 1'b0;
      waitn(20);
      lat_check(12'h00A);
      $display("done second reset");
   endtask

   initial begin
      rst = 1'b1;
      fast_path_disable_bit = 1'b0;
      gain_code = 4'h0;
      twos_comp_sel = 1'b0;
      out_ready = 1'b1;
      ramp = 1'b0;
      fixed_val = 12'h000;
      num_errors = 0;
      n_tests = 0;
      waitn(3);
      cmp1(gain_active, 1'b0);
      cmp1(out_valid, 1'b0);
      rst = 1'b0;
      t_fast();
      t_proc();
      t_gain();
      t_twos();
      t_fifo();
      t_reset2();
      wrap_up();
   end
endmodule
`default_nettype wire
